// ===== src/switch_global_power_control_regs.vh
// register offsets, field positions, reset values and timing counts for global/power control
`ifndef SWITCH_GLOBAL_POWER_CONTROL_REGS_VH
`define SWITCH_GLOBAL_POWER_CONTROL_REGS_VH
`define GIC_OFFSET        8'h0C
`define FTC_OFFSET        8'h0D
`define PMC_OFFSET        8'h0E
`define SDC_OFFSET        8'h0F
`define GIC_STRAP_BIT     6
`define GIC_CLKSEL_HI     5
`define GIC_CLKSEL_LO     4
`define GIC_PREAMBLE_BIT  2
`define GIC_TAILTAG_BIT   1
`define GIC_PASSFC_BIT    0
`define PMC_PLLPD_BIT     5
`define PMC_MODE_HI       4
`define PMC_MODE_LO       3
`define CLKSEL_RESET      2'h1
`define PREAMBLE_RESET    1'h1
`define TAILTAG_RESET     1'h0
`define PASSFC_RESET      1'h0
`define PLLPD_RESET       1'h0
`define MODE_NORMAL       2'h0
`define MODE_ENERGY       2'h1
`define MODE_SOFTDOWN     2'h2
`define MODE_SAVING       2'h3
`define SLEEP_RESET       8'h50
`define FACTORY_RESET     8'h00
`define SLEEP_UNIT_MS     20
`define CLK_MHZ           25
`define SLEEP_UNIT_CYCLES 20'h7A120 // one 20 ms unit counted in 25 MHz cycles
`endif

// ===== src/switch_global_power_control.v
// global control and power-management register group with sleep-delay timer
// Operation
// - the clock-mode status bit reads back the level of the clock-mode strap.
// - in normal mode the reduced-MII clock is taken from the external pin, not the PLL.
// - the two-bit clock select picks 41.67, 83.33 (reset) or 125 MHz; 11 is reserved.
// - preamble restore (reset 1) makes the fifth transceiver at 10 Mb/s regenerate preamble.
// - trailer-tag enable inserts one byte before the FCS on fifth-port frames only.
// - pass-flow-control 1 forwards flow-control frames, 0 filters them.
// - PLL power-down 0 keeps the PLL on, 1 powers it down during energy-detect sleep.
// - the power field selects normal, energy detection, soft power-down or power saving.
// - the power field reset value comes from a strap: low gives energy detect, high normal.
// - the sleep delay field resets to 80, a default of 1.6 seconds.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "switch_global_power_control_regs.vh"
module switch_global_power_control #(
   parameter [19:0] SLEEP_UNIT = `SLEEP_UNIT_CYCLES
) (
   input  wire       sys_clk,
   input  wire       rst,
   input  wire [7:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWrStb,
   input  wire       regRdStb,
   output reg  [7:0] regRdData,
   input  wire       rmiiClockStrapPin,
   input  wire       powerStateStrapPin,
   input  wire       energyDetected,
   output reg        rmiiClockMode,
   output reg  [1:0] interfaceClockSelect,
   output reg        preambleRestoreEnable,
   output reg        trailerTagEnable,
   output reg        passFlowControl,
   output reg  [1:0] powerMode,
   output reg        pllPowerDown,
   output reg        lowPowerState
);

   //----------------------------------------
   // local constants
   //----------------------------------------
   // one-hot codes of the sleep-delay timer
   localparam [2:0]  ST_AWAKE  = 3'h1;
   localparam [2:0]  ST_QUIET  = 3'h2;
   localparam [2:0]  ST_ASLEEP = 3'h4;
   // last count of one sleep unit
   localparam [19:0] UNIT_LAST = SLEEP_UNIT - 20'h00001;

   //----------------------------------------
   // helper functions
   //----------------------------------------
   // address match shared by the write decode
   function addrHit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addrHit = (addr == offset);
      end
   endfunction

   // power field value selected by the power-state strap
   function [1:0] strapPowerMode;
      input strapLevel;
      begin
         strapPowerMode = strapLevel ? `MODE_NORMAL : `MODE_ENERGY;
      end
   endfunction

   // read image of the interface control byte, unused bits held at zero
   function [7:0] packGic;
      input       strap;
      input [1:0] clkSel;
      input       preamble;
      input       tailTag;
      input       passFc;
      begin
         packGic                                = 8'h00;
         packGic[`GIC_STRAP_BIT]                = strap;
         packGic[`GIC_CLKSEL_HI:`GIC_CLKSEL_LO] = clkSel;
         packGic[`GIC_PREAMBLE_BIT]             = preamble;
         packGic[`GIC_TAILTAG_BIT]              = tailTag;
         packGic[`GIC_PASSFC_BIT]               = passFc;
      end
   endfunction

   // read image of the power control byte, reserved bits held at zero
   function [7:0] packPmc;
      input       pllEn;
      input [1:0] mode;
      begin
         packPmc                            = 8'h00;
         packPmc[`PMC_PLLPD_BIT]            = pllEn;
         packPmc[`PMC_MODE_HI:`PMC_MODE_LO] = mode;
      end
   endfunction

   //----------------------------------------
   // storage and next values
   //----------------------------------------
   reg         strapLoad_r;
   reg         rmiiClockMode_nxt;
   reg  [1:0]  clkSel_nxt;
   reg         preamble_nxt;
   reg         tailTag_nxt;
   reg         passFc_nxt;
   reg  [1:0]  powerMode_nxt;
   reg         pllPdEn_r;
   reg         pllPdEn_nxt;
   reg  [7:0]  sleepDelay_r;
   reg  [7:0]  sleepDelay_nxt;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [19:0] unitCnt_r;
   reg  [19:0] unitCnt_nxt;
   reg  [7:0]  unitsIdle_r;
   reg  [7:0]  unitsIdle_nxt;
   reg         lowPowerState_nxt;
   reg         pllPowerDown_nxt;
   reg  [7:0]  regRdData_nxt;
   wire        wrGic;
   wire        wrPmc;
   wire        wrSdc;
   wire        quietLine;

   //----------------------------------------
   // write decode
   //----------------------------------------
   // a strobe to an unmapped address decodes to nothing and is dropped
   assign wrGic = regWrStb && addrHit(regAddr, `GIC_OFFSET);
   assign wrPmc = regWrStb && addrHit(regAddr, `PMC_OFFSET);
   assign wrSdc = regWrStb && addrHit(regAddr, `SDC_OFFSET);
   // the line counts as quiet only while energy-detect mode is selected
   assign quietLine = !energyDetected && (powerMode == `MODE_ENERGY);

   //----------------------------------------
   // strap capture
   //----------------------------------------
   // straps caught on the first edge after reset release, never inside reset
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strapLoad_r <= 1'h1;
      end else begin
         strapLoad_r <= 1'h0;
      end
   end

   //----------------------------------------
   // global interface control
   //----------------------------------------
   // the strap status bit has no write path, so a host write cannot move the mode
   always @* begin
      rmiiClockMode_nxt = rmiiClockMode;
      clkSel_nxt        = interfaceClockSelect;
      preamble_nxt      = preambleRestoreEnable;
      tailTag_nxt       = trailerTagEnable;
      passFc_nxt        = passFlowControl;
      if (strapLoad_r) begin
         rmiiClockMode_nxt = rmiiClockStrapPin;
      end
      if (wrGic) begin
         // code 11 is stored as written; the clock tree treats it as reserved
         clkSel_nxt   = regWrData[`GIC_CLKSEL_HI:`GIC_CLKSEL_LO];
         preamble_nxt = regWrData[`GIC_PREAMBLE_BIT];
         tailTag_nxt  = regWrData[`GIC_TAILTAG_BIT];
         passFc_nxt   = regWrData[`GIC_PASSFC_BIT];
      end
   end

   // clock mode starts at the pull-up default until the strap is seen
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rmiiClockMode         <= 1'h1;
         interfaceClockSelect  <= `CLKSEL_RESET;
         preambleRestoreEnable <= `PREAMBLE_RESET;
         trailerTagEnable      <= `TAILTAG_RESET;
         passFlowControl       <= `PASSFC_RESET;
      end else begin
         rmiiClockMode         <= rmiiClockMode_nxt;
         interfaceClockSelect  <= clkSel_nxt;
         preambleRestoreEnable <= preamble_nxt;
         trailerTagEnable      <= tailTag_nxt;
         passFlowControl       <= passFc_nxt;
      end
   end

   //----------------------------------------
   // power management control
   //----------------------------------------
   // a host write on the strap edge loses its mode field to the strap value
   always @* begin
      powerMode_nxt = powerMode;
      pllPdEn_nxt   = pllPdEn_r;
      if (strapLoad_r) begin
         powerMode_nxt = strapPowerMode(powerStateStrapPin);
      end else if (wrPmc) begin
         // soft power-down is not guarded against a read back, software must avoid it
         powerMode_nxt = regWrData[`PMC_MODE_HI:`PMC_MODE_LO];
      end
      if (wrPmc) begin
         pllPdEn_nxt = regWrData[`PMC_PLLPD_BIT];
      end
   end

   // power field and pll enable registers
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         powerMode <= `MODE_NORMAL;
         pllPdEn_r <= `PLLPD_RESET;
      end else begin
         powerMode <= powerMode_nxt;
         pllPdEn_r <= pllPdEn_nxt;
      end
   end

   //----------------------------------------
   // sleep delay control
   //----------------------------------------
   // a new delay acts on the running count, no restart needed
   always @* begin
      sleepDelay_nxt = sleepDelay_r;
      if (wrSdc) begin
         sleepDelay_nxt = regWrData;
      end
   end

   // sleep delay register
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sleepDelay_r <= `SLEEP_RESET;
      end else begin
         sleepDelay_r <= sleepDelay_nxt;
      end
   end

   //----------------------------------------
   // sleep-delay timer
   //----------------------------------------
   // any energy or leaving energy mode drops back to awake and restarts the count
   always @* begin
      state_nxt         = state_r;
      unitCnt_nxt       = unitCnt_r;
      unitsIdle_nxt     = unitsIdle_r;
      lowPowerState_nxt = 1'h0;
      case (state_r)
         ST_AWAKE: begin
            unitCnt_nxt   = 20'h00000;
            unitsIdle_nxt = 8'h00;
            if (quietLine) begin
               state_nxt = ST_QUIET;
            end
         end
         ST_QUIET: begin
            if (!quietLine) begin
               state_nxt = ST_AWAKE;
            end else if (unitsIdle_r >= sleepDelay_r) begin
               state_nxt         = ST_ASLEEP;
               lowPowerState_nxt = 1'h1;
            end else if (unitCnt_r == UNIT_LAST) begin
               unitCnt_nxt   = 20'h00000;
               unitsIdle_nxt = unitsIdle_r + 8'h01;
            end else begin
               unitCnt_nxt = unitCnt_r + 20'h00001;
            end
         end
         ST_ASLEEP: begin
            if (!quietLine) begin
               state_nxt = ST_AWAKE;
            end else begin
               lowPowerState_nxt = 1'h1;
            end
         end
         default: begin
            state_nxt = ST_AWAKE;
         end
      endcase
      // pll only drops while asleep and only when software allowed it
      pllPowerDown_nxt = pllPdEn_r && lowPowerState;
   end

   // timer state and the two power outputs
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r       <= ST_AWAKE;
         unitCnt_r     <= 20'h00000;
         unitsIdle_r   <= 8'h00;
         lowPowerState <= 1'h0;
         pllPowerDown  <= 1'h0;
      end else begin
         state_r       <= state_nxt;
         unitCnt_r     <= unitCnt_nxt;
         unitsIdle_r   <= unitsIdle_nxt;
         lowPowerState <= lowPowerState_nxt;
         pllPowerDown  <= pllPowerDown_nxt;
      end
   end

   //----------------------------------------
   // read port
   //----------------------------------------
   // reserved and factory bits are wired to zero, so writes there cannot stick
   always @* begin
      regRdData_nxt = 8'h00;
      if (regRdStb) begin
         case (regAddr)
            `GIC_OFFSET: regRdData_nxt = packGic(rmiiClockMode, interfaceClockSelect,
                                                 preambleRestoreEnable, trailerTagEnable,
                                                 passFlowControl);
            `FTC_OFFSET: regRdData_nxt = `FACTORY_RESET;
            `PMC_OFFSET: regRdData_nxt = packPmc(pllPdEn_r, powerMode);
            `SDC_OFFSET: regRdData_nxt = sleepDelay_r;
            default:     regRdData_nxt = 8'h00;
         endcase
      end
   end

   // read data stands in the cycle after each strobe cycle, zero otherwise
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= regRdData_nxt;
      end
   end

endmodule // switch_global_power_control
`default_nettype wire

// ===== tb/gpc_monitor.sv
// assertions on the global and power control register ports
`timescale 1ns/1ps
`default_nettype none
module gpc_monitor (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       regWrStb,
   input wire logic       regRdStb,
   input wire logic       energyDetected,
   input wire logic       rmiiClockMode,
   input wire logic       preambleRestoreEnable,
   input wire logic       trailerTagEnable,
   input wire logic       passFlowControl,
   input wire logic       pllPowerDown,
   input wire logic       lowPowerState,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic [1:0] interfaceClockSelect,
   input wire logic [1:0] powerMode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // writes to the interface control byte
   wire gw = regWrStb && regAddr == 8'h0C;
   a_read_idle: assert property (!$past(regRdStb) |-> regRdData == 8'h00) else $error("rd idle");
   a_strap_read: assert property (regRdStb && regAddr == 8'h0C |=>
      regRdData[6] == rmiiClockMode) else $error("strap bit");
   a_clksel_write: assert property (gw |=>
      interfaceClockSelect == $past(regWrData[5:4])) else $error("clksel");
   a_preamble_write: assert property (gw |=>
      preambleRestoreEnable == $past(regWrData[2])) else $error("preamble");
   a_tail_pass: assert property (gw |=> {trailerTagEnable, passFlowControl}
      == $past(regWrData[1:0])) else $error("tail or pass");
   a_mode_write: assert property (regWrStb && regAddr == 8'h0E |=>
      powerMode == $past(regWrData[4:3])) else $error("mode");
   a_factory_zero: assert property (regRdStb && regAddr == 8'h0D |=>
      regRdData == 8'h00) else $error("factory");
   // the strap load lands one edge after release, so wait two edges
   a_strap_hold: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(rmiiClockMode))
      else $error("strap moved");
   a_pll_gate: assert property (!lowPowerState |=> !pllPowerDown) else $error("pll");
   a_energy_wake: assert property (energyDetected |=> !lowPowerState) else $error("wake");
   a_sleep_mode: assert property (powerMode != 2'h1 |=> !lowPowerState)
      else $error("sleep outside energy mode");
   a_pll_cause: assert property (pllPowerDown |-> $past(lowPowerState))
      else $error("pll down without sleep");
endmodule // gpc_monitor
`default_nettype wire

// ===== tb/line_model.sv
// line energy and strap pin model facing the power control block
`timescale 1ns/1ps
`default_nettype none
module line_model (
   input  wire logic lineActive,
   input  wire logic pdStrap,
   output wire logic rmiiClockStrapPin,
   output wire logic powerStateStrapPin,
   output wire logic energyDetected
);
   // both straps follow one bench level, so a pulled-down run flips both modes
   assign rmiiClockStrapPin = pdStrap;
   assign powerStateStrapPin = pdStrap;
   assign energyDetected = lineActive;
endmodule // line_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the global and power control register group
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin total_checks++; if ((a) !== (e)) begin failures++; \
   $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
   logic sys_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0, lineActive = 0, pdStrap = 1;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
   wire rmiiClockStrapPin, powerStateStrapPin, energyDetected, rmiiClockMode, pllPowerDown;
   wire preambleRestoreEnable, trailerTagEnable, passFlowControl, lowPowerState;
   wire [7:0] regRdData;
   wire [1:0] interfaceClockSelect, powerMode;
   wire [2:0] feat = {preambleRestoreEnable, trailerTagEnable, passFlowControl};
   int failures = 0, total_checks = 0, cycles = 0;
   always #20 sys_clk = ~sys_clk;
   // short sleep unit keeps the delay test brief
   switch_global_power_control #(.SLEEP_UNIT(20'd4)) switch_global_power_control_i (.*);
   line_model line_model_i (.lineActive, .pdStrap, .rmiiClockStrapPin, .powerStateStrapPin,
      .energyDetected);
   task give_verdict;
      if (failures == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard, far above the expected run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin failures++; give_verdict; end
   end
   task automatic wr(input logic [7:0] a, d);
      @(posedge sys_clk); regWrStb <= 1; regAddr <= a; regWrData <= d;
      @(posedge sys_clk); regWrStb <= 0;
   endtask
   task automatic rdc(input logic [7:0] a, e);
      @(posedge sys_clk); regRdStb <= 1; regAddr <= a;
      @(posedge sys_clk); regRdStb <= 0; #1 `CHK("read", e, regRdData)
   endtask
   task automatic do_reset(input logic s);
      @(posedge sys_clk); pdStrap <= s; rst <= 1; repeat (12) @(posedge sys_clk);
      rst <= 0; repeat (2) @(posedge sys_clk);
   endtask
   task automatic t_defaults;
      rdc(8'h0C, 8'h54);
      rdc(8'h0D, 8'h00);
      rdc(8'h0E, 8'h00);
      rdc(8'h0F, 8'h50);
      wr(8'h33, 8'hFF); rdc(8'h33, 8'h00);
   endtask
   // every clock select code, with read-only and unused bits written low
   task automatic t_gic;
      for (int i = 0; i < 4; i++) begin
         wr(8'h0C, {2'b00, i[1:0], 4'h7});
         #1 `CHK("clksel", i[1:0], interfaceClockSelect)
         rdc(8'h0C, {2'b01, i[1:0], 4'h7});
      end
      `CHK("feat on", 3'h7, feat)
      wr(8'h0C, 8'h00);
      #1 `CHK("feat", 3'b000, feat)
   endtask
   task automatic t_modes;
      for (int i = 0; i < 4; i++) begin
         wr(8'h0E, {3'b001, i[1:0], 3'b000});
         // soft power-down is never read back, its output is watched instead
         if (i == 2) begin #1 `CHK("soft", 2'h2, powerMode) end
         else rdc(8'h0E, {3'b001, i[1:0], 3'b000});
      end
   endtask
   // two units of quiet line before sleep, then a wake on energy
   task automatic t_sleep;
      wr(8'h0F, 8'h02); wr(8'h0E, 8'h28);
      repeat (8) @(posedge sys_clk); #1 `CHK("early", 1'b0, lowPowerState)
      for (int k = 0; k < 20 && lowPowerState !== 1'b1; k++) begin @(posedge sys_clk); #1; end
      @(posedge sys_clk); #1 `CHK("pll", 2'b11, {lowPowerState, pllPowerDown})
      @(posedge sys_clk) lineActive <= 1;
      @(posedge sys_clk); #1 `CHK("wake", 1'b0, lowPowerState)
   endtask
   initial begin
      do_reset(1'b1); t_defaults; t_gic; t_modes; t_sleep;
      do_reset(1'b0); rdc(8'h0E, 8'h08);
      rdc(8'h0C, 8'h14);
      give_verdict;
   end
endmodule // tb_top
bind switch_global_power_control gpc_monitor gpc_monitor_i (.*);
`default_nettype wire
